// File: design/ci_alarm_change_interrupt.sv
// Purpose: sticky change status, enables and interrupt for AIS-CI and RAI-CI
// Assumes: detector levels and esf_mode come from logic on ref_clk
// Notes:   classic Wishbone slave, 8-bit data in lane 0, one wait state
`default_nettype none
module ci_alarm_change_interrupt
	import cia_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [13:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// alarm detector levels and framing mode
	input wire logic ais_ci_detect,
	input wire logic rai_ci_detect,
	input wire logic esf_mode,
	// interrupt request, active high
	output logic irq_o
);
	cia_bus_st_t bus_st_ff;
	logic [7:0] rdata_ff;
	logic [1:0] status_ff;
	logic [1:0] enable_ff;
	logic [1:0] detctl_ff;
	logic irq_ff;
	logic ack_ff;
	logic take;
	logic rd_status;
	logic wr_lane0;
	logic [IDX_W-1:0] idx;
	logic [1:0] nxt_status;

	cia_chg_if chg ();

	// ==========================================================
	// register index decode
	function automatic logic hit(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] r);
		hit = (a == r);
	endfunction : hit

	assign idx = wb_adr_i[13:2];
	// a request is taken once, in the idle state; the ack cycle ignores it
	assign take = wb_cyc_i && wb_stb_i && (bus_st_ff == CIA_BUS_IDLE);
	assign rd_status = take && !wb_we_i && hit(idx, REG_STATUS_IDX);
	assign wr_lane0 = take && wb_we_i && wb_sel_i[0];

	// ==========================================================
	// qualify detector levels before change detection
	always_comb begin
		chg.cond = 2'h0;
		chg.cond[BIT_AIS] = ais_ci_detect && detctl_ff[BIT_AIS];
		chg.cond[BIT_RAI] = rai_ci_detect && detctl_ff[BIT_RAI] && esf_mode;
	end

	cia_change_det u_det (
		.ref_clk(ref_clk),
		.reset(reset),
		.chg(chg)
	);

	// ==========================================================
	// sticky status: a change in the read cycle survives the clear
	always_comb begin
		nxt_status = status_ff;
		if (rd_status) begin
			nxt_status = STATUS_RST;
		end
		nxt_status = nxt_status | chg.change;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			status_ff <= STATUS_RST;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// ==========================================================
	// software registers: interrupt enables and detection enables
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			enable_ff <= ENABLE_RST;
			detctl_ff <= DETCTL_RST;
		end else if (wr_lane0) begin
			if (hit(idx, REG_ENABLE_IDX)) begin
				enable_ff <= wb_dat_i[1:0];
			end
			if (hit(idx, REG_DETCTL_IDX)) begin
				detctl_ff <= wb_dat_i[1:0];
			end
		end
	end

	// ==========================================================
	// interrupt output, registered so it comes straight from a flop
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(status_ff & enable_ff);
		end
	end

	// ==========================================================
	// bus handshake: ack one cycle after take, dropped the next
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bus_st_ff <= CIA_BUS_IDLE;
		end else begin
			case (bus_st_ff)
				CIA_BUS_IDLE: begin
					if (take) begin
						bus_st_ff <= CIA_BUS_ACK;
					end
				end
				CIA_BUS_ACK: begin
					bus_st_ff <= CIA_BUS_IDLE;
				end
				default: begin
					bus_st_ff <= CIA_BUS_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// ack from its own flop so the pin carries no decode; a held
	// request is not re-taken in the ack cycle, so ack lasts one cycle
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= take;
		end
	end

	// ==========================================================
	// read data captured at take, the same edge the status clears;
	// unmapped addresses read zero and are still acked
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rdata_ff <= DATA_RST;
		end else if (take && !wb_we_i) begin
			rdata_ff <= DATA_RST;
			if (hit(idx, REG_STATUS_IDX)) begin
				rdata_ff[BIT_AIS] <= status_ff[BIT_AIS];
				rdata_ff[BIT_RAI] <= status_ff[BIT_RAI];
				rdata_ff[BIT_AIS_LIVE] <= chg.state[BIT_AIS];
				rdata_ff[BIT_RAI_LIVE] <= chg.state[BIT_RAI];
			end else if (hit(idx, REG_ENABLE_IDX)) begin
				rdata_ff[1:0] <= enable_ff;
			end else if (hit(idx, REG_DETCTL_IDX)) begin
				rdata_ff[1:0] <= detctl_ff;
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = {24'h000000, rdata_ff};
	assign irq_o = irq_ff;

	// ==========================================================
	// assertions
	a_ais_change_sets: assert property (@(posedge ref_clk) disable iff (reset)
		chg.change[BIT_AIS] |=> status_ff[BIT_AIS]) else $error("ais change not latched");
	a_rai_change_sets: assert property (@(posedge ref_clk) disable iff (reset)
		chg.change[BIT_RAI] |=> status_ff[BIT_RAI]) else $error("rai change not latched");
	// after a status read, only bits whose change was seen in the read cycle itself may stay set
	a_status_read_clear: assert property (@(posedge ref_clk) disable iff (reset)
		rd_status |=> wb_ack_o && ((status_ff & ~$past(chg.change)) == STATUS_RST)) else $error("read clear");
	a_read_data: assert property (@(posedge ref_clk) disable iff (reset)
		rd_status |=> wb_dat_o[BIT_AIS] == $past(status_ff[BIT_AIS]) && wb_dat_o[BIT_RAI] == $past(status_ff[BIT_RAI]))
		else $error("status read data wrong");
	a_status_sticky: assert property (@(posedge ref_clk) disable iff (reset)
		status_ff[BIT_RAI] && !rd_status |=> status_ff[BIT_RAI]) else $error("status lost");
	a_status_quiet: assert property (@(posedge ref_clk) disable iff (reset)
		!rd_status && !(|chg.change) |=> status_ff == $past(status_ff)) else $error("status moved unprompted");
	a_enable_write: assert property (@(posedge ref_clk) disable iff (reset)
		wr_lane0 && hit(idx, REG_ENABLE_IDX) |=> enable_ff == $past(wb_dat_i[1:0])) else $error("enable");
	a_enable_hold: assert property (@(posedge ref_clk) disable iff (reset)
		!(wr_lane0 && hit(idx, REG_ENABLE_IDX)) |=> enable_ff == $past(enable_ff)) else $error("enable drifted");
	a_irq_follows: assert property (@(posedge ref_clk) disable iff (reset)
		(status_ff[BIT_AIS] && enable_ff[BIT_AIS]) |=> irq_o) else $error("irq missing");
	a_rai_irq_follows: assert property (@(posedge ref_clk) disable iff (reset)
		(status_ff[BIT_RAI] && enable_ff[BIT_RAI]) |=> irq_o) else $error("rai irq missing");
	a_irq_gated: assert property (@(posedge ref_clk) disable iff (reset)
		!(|(status_ff & enable_ff)) |=> !irq_o) else $error("irq without cause");
	// checked through the change flop, so a broken qualifier shows up
	a_rai_esf_only: assert property (@(posedge ref_clk) disable iff (reset)
		!esf_mode |=> !chg.state[BIT_RAI]) else $error("rai outside esf");
	a_detect_gated: assert property (@(posedge ref_clk) disable iff (reset)
		!detctl_ff[BIT_AIS] |=> !chg.state[BIT_AIS]) else $error("ais not gated");
	a_rai_detect_gated: assert property (@(posedge ref_clk) disable iff (reset)
		!detctl_ff[BIT_RAI] |=> !chg.state[BIT_RAI]) else $error("rai not gated");
	a_ack_single: assert property (@(posedge ref_clk) disable iff (reset)
		take |=> wb_ack_o ##1 !wb_ack_o) else $error("ack shape");

	// ==========================================================
	// coverage of the main scenarios
	c_ais_change: cover property (@(posedge ref_clk) disable iff (reset) chg.change[BIT_AIS]);
	c_rai_change: cover property (@(posedge ref_clk) disable iff (reset) chg.change[BIT_RAI]);
	c_read_race: cover property (@(posedge ref_clk) disable iff (reset) rd_status && |chg.change);
	c_irq_rise: cover property (@(posedge ref_clk) disable iff (reset) !irq_o ##1 irq_o);
	c_status_write: cover property (@(posedge ref_clk) disable iff (reset) take && wb_we_i && hit(idx, REG_STATUS_IDX));
endmodule : ci_alarm_change_interrupt
`default_nettype wire

// File: design/cia_change_det.sv
// Purpose: flags every onset and clearing of each qualified alarm condition
// Assumes: conditions are produced on ref_clk
// Notes:   change is a one-cycle pulse, state is the registered condition
`default_nettype none
module cia_change_det
	import cia_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// conditions in, changes out
	cia_chg_if.det chg
);
	logic [1:0] prev_ff;

	// ==========================================================
	// remember last condition; both edges count as a change
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			prev_ff <= STATUS_RST;
		end else begin
			prev_ff <= chg.cond;
		end
	end

	assign chg.change = chg.cond ^ prev_ff;
	assign chg.state = prev_ff;
endmodule : cia_change_det
`default_nettype wire

// File: design/cia_chg_if.sv
// Purpose: carries qualified alarm conditions and their change pulses
// Assumes: single clock domain
// Notes:   bit 1 is AIS-CI, bit 0 is RAI-CI
`default_nettype none
interface cia_chg_if;
	logic [1:0] cond;
	logic [1:0] change;
	logic [1:0] state;
	modport det (input cond, output change, output state);
	modport ctl (output cond, input change, input state);
endinterface : cia_chg_if
`default_nettype wire

// File: design/cia_pkg.sv
// Purpose: shared constants for the customer-installation alarm change interrupt block
// Assumes: word-indexed register map, byte address = 4 * index
// Notes:   register indices carry the channel nibble as zero
`default_nettype none
package cia_pkg;
	// ==========================================================
	// register map
	localparam int unsigned IDX_W = 12;
	localparam logic [IDX_W-1:0] REG_STATUS_IDX = 12'hB40;
	localparam logic [IDX_W-1:0] REG_ENABLE_IDX = 12'hB41;
	localparam logic [IDX_W-1:0] REG_DETCTL_IDX = 12'hB42;
	// ==========================================================
	// field positions
	localparam int unsigned BIT_RAI = 0;
	localparam int unsigned BIT_AIS = 1;
	localparam int unsigned BIT_RAI_LIVE = 4;
	localparam int unsigned BIT_AIS_LIVE = 5;
	// ==========================================================
	// reset values
	localparam logic [1:0] STATUS_RST = 2'h0;
	localparam logic [1:0] ENABLE_RST = 2'h0;
	localparam logic [1:0] DETCTL_RST = 2'h0;
	localparam logic [7:0] DATA_RST = 8'h00;
	// ==========================================================
	// bus slave states
	typedef enum logic [1:0] {
		CIA_BUS_IDLE = 2'b01,
		CIA_BUS_ACK = 2'b10
	} cia_bus_st_t;
endpackage : cia_pkg
`default_nettype wire

// File: tb/ci_alarm_change_interrupt_tb_top.sv
// Purpose: register-level test of the alarm change interrupt block
// Assumes: one wait state Wishbone slave, but the master waits for ack
// Notes:   detector changes need three edges to reach irq_o, so steps wait four
`default_nettype none
module ci_alarm_change_interrupt_tb_top
	import cia_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================
	// addresses and bench signals
	localparam logic [13:0] A_ST = {REG_STATUS_IDX, 2'h0};
	localparam logic [13:0] A_EN = {REG_ENABLE_IDX, 2'h0};
	localparam logic [13:0] A_DC = {REG_DETCTL_IDX, 2'h0};
	localparam logic [13:0] A_UN = 14'h2D0C;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, ais, rai, esf;
	logic s_ais = 1'b0, s_rai = 1'b0, s_esf = 1'b0;
	logic [13:0] adr = 14'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, dat_o, rd;
	int err_total = 0, n_tests = 0, cyc_cnt = 0;
	always #12.5 ref_clk = ~ref_clk;
	ci_alarm_change_interrupt u_dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.ais_ci_detect(ais), .rai_ci_detect(rai), .esf_mode(esf), .irq_o(irq));
	cia_det_model u_det (.ref_clk(ref_clk), .reset(reset), .set_ais(s_ais), .set_rai(s_rai),
		.set_esf(s_esf), .ais_ci_detect(ais), .rai_ci_detect(rai), .esf_mode(esf));
	// =====================================================
	// tasks: verdict, compare, bus cycle, detector step
	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("BAD %s exp %h got %h", nm, exp, got);
			err_total++;
		end
	endtask : chk
	// hold the request until ack is sampled, then release for one cycle
	task automatic wb(input logic w, input logic [13:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dat_o;
		if (ack !== 1'b1) chk("ack wait", 32'h1, 32'h0);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge ref_clk);
	endtask : wb
	task automatic drv(input logic a, input logic r, input logic e);
		s_ais <= a;
		s_rai <= r;
		s_esf <= e;
		repeat (4) @(posedge ref_clk);
	endtask : drv
	// timeout: the whole sequence needs under two hundred cycles, so the ceiling is generous
	always @(posedge ref_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			err_total++;
			test_done();
		end
	end
	// =====================================================
	// main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		wb(1'b0, A_ST, 32'h0);
		chk("status reset", 32'h0, rd);
		wb(1'b0, A_EN, 32'h0);
		chk("enable reset", 32'h0, rd);
		wb(1'b1, A_DC, 32'h3);
		drv(1'b1, 1'b0, 1'b0);
		chk("irq masked", 32'h0, {31'h0, irq});
		wb(1'b0, A_ST, 32'h0);
		chk("ais onset", 32'h22, rd);
		wb(1'b0, A_ST, 32'h0);
		chk("status cleared", 32'h20, rd);
		wb(1'b1, A_EN, 32'h2);
		wb(1'b0, A_EN, 32'h0);
		chk("enable ais", 32'h2, rd);
		drv(1'b0, 1'b0, 1'b0);
		chk("irq ais clear", 32'h1, {31'h0, irq});
		wb(1'b0, A_ST, 32'h0);
		chk("ais clearing", 32'h2, rd);
		chk("irq after read", 32'h0, {31'h0, irq});
		drv(1'b0, 1'b1, 1'b0);
		wb(1'b0, A_ST, 32'h0);
		chk("rai without esf", 32'h0, rd);
		wb(1'b1, A_EN, 32'h1);
		drv(1'b0, 1'b1, 1'b1);
		chk("irq rai onset", 32'h1, {31'h0, irq});
		wb(1'b0, A_ST, 32'h0);
		chk("rai onset", 32'h11, rd);
		drv(1'b0, 1'b0, 1'b1);
		wb(1'b1, A_ST, 32'h0);
		wb(1'b0, A_ST, 32'h0);
		chk("rai clearing", 32'h1, rd);
		wb(1'b0, A_UN, 32'h0);
		chk("unmapped read", 32'h0, rd);
		// ais detection off: a live ais level must not reach the status
		wb(1'b1, A_DC, 32'h1);
		drv(1'b1, 1'b0, 1'b1);
		wb(1'b0, A_ST, 32'h0);
		chk("ais detect off", 32'h0, rd);
		// turning detection on while ais stands counts as an onset
		wb(1'b1, A_DC, 32'h3);
		drv(1'b1, 1'b0, 1'b1);
		chk("irq ais disabled", 32'h0, {31'h0, irq});
		wb(1'b0, A_ST, 32'h0);
		chk("ais detect on", 32'h22, rd);
		// second reset in mid-run: enables and status return to zero
		reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		wb(1'b0, A_EN, 32'h0);
		chk("enable after reset", 32'h0, rd);
		wb(1'b0, A_ST, 32'h0);
		chk("status after reset", 32'h0, rd);
		test_done();
	end
endmodule : ci_alarm_change_interrupt_tb_top
`default_nettype wire

// File: tb/cia_det_model.sv
// Purpose: stand-in for the receive framer alarm detectors
// Assumes: the bench sets the wanted levels just after a rising edge
// Notes:   levels are registered, so they change on ref_clk like real detector flops
`default_nettype none
module cia_det_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// wanted levels from the bench
	input wire logic set_ais,
	input wire logic set_rai,
	input wire logic set_esf,
	// detector levels toward the block
	output logic ais_ci_detect,
	output logic rai_ci_detect,
	output logic esf_mode
);
	// =====================================================
	// detector flops, cleared by device reset like the framer
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ais_ci_detect <= 1'b0;
			rai_ci_detect <= 1'b0;
			esf_mode <= 1'b0;
		end else begin
			ais_ci_detect <= set_ais;
			rai_ci_detect <= set_rai;
			esf_mode <= set_esf;
		end
	end
endmodule : cia_det_model
`default_nettype wire
